// *** cfb_branch.sv ***
// Behaviour
// - transfer flag clear: pc gets pc+k+1
// - overflow set: pc gets pc+k+1
// - overflow clear: pc gets pc+k+1
// - interrupts enabled: pc gets pc+k+1
// - interrupts disabled: pc gets pc+k+1
`timescale 1ns/1ps
module cfb_branch #(
  parameter int PC_W = cfb_pkg::PC_W,
  parameter int OFS_W = cfb_pkg::OFS_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // instruction issue
  input wire logic issue_valid_i,
  input wire cfb_pkg::cfb_instr_t issue_instr_i,
  output logic issue_ready_o,
  // status flags from the core
  input wire logic [cfb_pkg::FLAG_W-1:0] flags_i,
  // program counter
  output logic [PC_W-1:0] program_counter_o,
  output logic done_o,
  output logic taken_o,
  output logic [cfb_pkg::FLAG_W-1:0] flags_o
);
  // two states are enough: a fall-through finishes in its issue cycle,
  // a taken branch needs one more cycle to commit the target
  typedef enum logic {CFB_IDLE, CFB_TAKE} cfb_state_t;

  // condition test of one op against the status flags
  function automatic logic cfb_cond_met(
    input cfb_pkg::cfb_op_t op,
    input logic [cfb_pkg::FLAG_W-1:0] flags
  );
    logic hit;
    hit = 1'b0;
    case (op)
      cfb_pkg::CFB_OP_TRANSFER_CLEAR: begin
        hit = !flags[cfb_pkg::FLAG_T];
      end
      cfb_pkg::CFB_OP_OVERFLOW_SET: begin
        hit = flags[cfb_pkg::FLAG_V];
      end
      cfb_pkg::CFB_OP_OVERFLOW_CLEAR: begin
        hit = !flags[cfb_pkg::FLAG_V];
      end
      cfb_pkg::CFB_OP_IRQ_ENABLED: begin
        hit = flags[cfb_pkg::FLAG_I];
      end
      cfb_pkg::CFB_OP_IRQ_DISABLED: begin
        hit = !flags[cfb_pkg::FLAG_I];
      end
      cfb_pkg::CFB_OP_NONE: begin
        hit = 1'b0;
      end
      default: begin
        // spare codes never branch, they only fall through
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // state and registered outputs
  cfb_state_t state_r;
  cfb_state_t state_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] target_r;
  logic [PC_W-1:0] target_nxt;
  logic done_r;
  logic done_nxt;
  logic taken_r;
  logic taken_nxt;

  // fields of the offered instruction
  wire cfb_pkg::cfb_op_t op = issue_instr_i.op;
  wire logic [OFS_W-1:0] offset = issue_instr_i.offset;

  // issue decode
  wire logic cond_hit = cfb_cond_met(op, flags_i);
  wire logic is_branch = (op != cfb_pkg::CFB_OP_NONE);
  wire logic accept = issue_valid_i && issue_ready_o;
  wire logic start = accept && is_branch;
  wire logic start_taken = start && cond_hit;
  wire logic start_fall = start && !cond_hit;
  wire logic in_idle = (state_r == CFB_IDLE);
  wire logic in_take = (state_r == CFB_TAKE);

  // offset is a signed word displacement, sign extended to pc width
  wire logic sign_bit = offset[OFS_W-1];
  wire logic [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){sign_bit}}, offset};
  wire logic [PC_W-1:0] pc_step = PC_W'(cfb_pkg::PC_STEP);
  wire logic [PC_W-1:0] pc_reset = PC_W'(cfb_pkg::PC_RESET);
  wire logic [PC_W-1:0] pc_plus1 = pc_r + pc_step;
  // target is formed from the pc at accept; wraps at the pc width
  wire logic [PC_W-1:0] target = pc_plus1 + ofs_ext;

  // ready drops only in the commit cycle of a taken branch
  assign issue_ready_o = in_idle;
  assign program_counter_o = pc_r;
  assign done_o = done_r;
  assign taken_o = taken_r;
  // no instruction of this group alters a status flag
  assign flags_o = flags_i;

  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    target_nxt = target_r;
    done_nxt = 1'b0;
    taken_nxt = 1'b0;
    case (state_r)
      CFB_IDLE: begin
        // target is captured every idle cycle, used only when taken
        target_nxt = target;
        if (start_taken) begin
          state_nxt = CFB_TAKE;
        end else if (start_fall) begin
          pc_nxt = pc_plus1;
          done_nxt = 1'b1;
        end
      end
      CFB_TAKE: begin
        // second cycle commits the jump target
        pc_nxt = target_r;
        done_nxt = 1'b1;
        taken_nxt = 1'b1;
        state_nxt = CFB_IDLE;
      end
      default: begin
        state_nxt = CFB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_r <= CFB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pc_r <= pc_reset;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      target_r <= pc_reset;
    end else begin
      target_r <= target_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      taken_r <= 1'b0;
    end else begin
      taken_r <= taken_nxt;
    end
  end
endmodule // cfb_branch

// *** cfb_pkg.sv ***
package cfb_pkg;
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int FLAG_W = 8;
  // status flag bit positions
  localparam int FLAG_T = 6;
  localparam int FLAG_V = 3;
  localparam int FLAG_I = 7;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
  localparam int TAKEN_CYCLES = 2;
  localparam int FALL_CYCLES = 1;

  typedef enum logic [2:0] {
    CFB_OP_NONE,
    CFB_OP_TRANSFER_CLEAR,
    CFB_OP_OVERFLOW_SET,
    CFB_OP_OVERFLOW_CLEAR,
    CFB_OP_IRQ_ENABLED,
    CFB_OP_IRQ_DISABLED
  } cfb_op_t;

  typedef struct packed {
    cfb_op_t op;
    logic [OFS_W-1:0] offset;
  } cfb_instr_t;
endpackage

// *** cfb_properties.sv ***
`timescale 1ns/1ps
module cfb_chk (input wire logic clock_i, resetn_i, issue_valid_i,
  issue_ready_o, done_o, taken_o, input wire cfb_pkg::cfb_instr_t issue_instr_i,
  input wire logic [7:0] flags_i, flags_o, input wire logic [15:0] program_counter_o);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire [2:0] o = issue_instr_i.op;
  wire [7:0] f = flags_i;
  wire [15:0] p = program_counter_o;
  wire a = issue_valid_i && issue_ready_o && o != 3'h0;
  wire c = o==3'h1&&!f[6] || o==3'h2&&f[3] || o==3'h3&&!f[3] || o==3'h4&&f[7]
    || o==3'h5&&!f[7];
  wire [15:0] t = p + 16'h0001 + 16'(signed'(issue_instr_i.offset));
  property p_tk; a&&c |-> ##2 done_o&&taken_o&&p==$past(t, 2); endproperty
  property p_ut; a&&!c |=> done_o&&!taken_o&&p==$past(p)+16'h0001; endproperty
  property p_st; a&&c |=> !issue_ready_o&&!done_o; endproperty
  property p_fl; flags_o == flags_i; endproperty
  property p_td; taken_o |-> done_o; endproperty
  property p_hd; !done_o |-> $stable(p); endproperty
  a_tk: assert property (p_tk) else $error("tk");
  a_ut: assert property (p_ut) else $error("ut");
  a_st: assert property (p_st) else $error("st");
  a_fl: assert property (p_fl) else $error("fl");
  a_td: assert property (p_td) else $error("td");
  a_hd: assert property (p_hd) else $error("hd");
  cover property (a && c);
  cover property (a && !c);
  cover property (done_o && taken_o);
endmodule // cfb_chk
bind cfb_branch cfb_chk u_cfb_chk (.*);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clock_i=0, resetn_i=0, issue_valid_i=0, issue_ready_o, done_o, taken_o, c;
  cfb_pkg::cfb_instr_t issue_instr_i = '0;
  logic [7:0] flags_i = 8'h00, flags_o;
  logic [15:0] program_counter_o, pc = 16'h0000;
  int errors=0, samples_checked=0, seed=67, n, j;
  cfb_branch u_cfb_branch (.*);
  initial forever #25 clock_i = ~clock_i;
  task chk(string s, logic [15:0] e, g);
    samples_checked++;
    errors += int'(g !== e);
    if (g !== e) $display("FAIL %s exp %h got %h", s, e, g);
  endtask
  task complete_run;
    $display("%0d checked, %0d errors", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    resetn_i = 1;
    for (int i = 0; i < 80; i++) begin
      // flag forced so taken and untaken come up about equally
      j = {$random(seed)} % 5;
      c = $random(seed);
      flags_i = 8'($random(seed));
      flags_i[j==0 ? 6 : j<3 ? 3 : 7] = c == j[0];
      issue_instr_i = {3'(j+1), i<2 ? 7'h3F+7'(i) : 7'($random(seed))};
      issue_valid_i = 1;
      @(negedge clock_i);
      issue_valid_i = 0;
      for (n = 0; n < 4 && done_o !== 1'b1; n++) @(negedge clock_i);
      pc = pc + 16'h0001 + (c ? 16'(signed'(issue_instr_i.offset)) : 16'h0000);
      chk("cycles", 16'(c), 16'(n));
      chk("taken", 16'(c), 16'(taken_o));
      chk("pc", pc, program_counter_o);
      chk("flags", 16'(flags_i), 16'(flags_o));
      $display("test %0d end", i);
      if (n == 4) complete_run;
    end
    // op none must be ignored: no pulse and the pc holds
    issue_instr_i = {3'h0, 7'($random(seed))};
    issue_valid_i = 1;
    @(negedge clock_i);
    issue_valid_i = 0;
    @(negedge clock_i);
    chk("none done", 16'h0000, 16'(done_o));
    chk("none pc", pc, program_counter_o);
    // reset in mid-run brings the pc back to its reset value
    resetn_i = 0;
    repeat (2) @(negedge clock_i);
    chk("reset pc", 16'h0000, program_counter_o);
    chk("reset done", 16'h0000, 16'(done_o));
    resetn_i = 1;
    $display("test none and reset end");
    complete_run;
  end
endmodule // tb_top
